// ### rtl/ssi_field_pick.sv
`timescale 1ns/1ns
// picks the selector and control nibble for one step
module ssi_field_pick (
   input wire logic [31:0] sel_word,
   input wire logic [31:0] ctl_word,
   input wire logic [2:0] step,
   output logic [1:0] sel,
   output logic end_flag,
   output logic ts_flag
);
   logic [3:0] sel_nib;
   logic [3:0] ctl_nib;

   // nibble extraction by step index
   always_comb begin
      sel_nib = sel_word[step * ssi_pkg::SEL_STRIDE +: 4];
      ctl_nib = ctl_word[step * ssi_pkg::CTL_STRIDE +: 4];
      sel = sel_nib[ssi_pkg::SEL_W-1:0];
      end_flag = ctl_nib[ssi_pkg::CTL_END_BIT];
      ts_flag = ctl_nib[ssi_pkg::CTL_TS_BIT];
   end
endmodule // ssi_field_pick

// ### rtl/ssi_pkg.sv
package ssi_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_INPUT_SEL = 12'h040;
   localparam logic [11:0] ADDR_SEQ_CTRL = 12'h044;
   localparam logic [11:0] ADDR_SEQ_STATUS = 12'h048;
   // reset values
   localparam logic [31:0] INPUT_SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] SEQ_CTRL_RESET = 32'h0000_0000;
   // writable bits of the input select register (selectors only)
   localparam logic [31:0] INPUT_SEL_WMASK = 32'h3333_3333;
   // geometry
   localparam int STEPS = 8;
   localparam int SEL_W = 2;
   localparam int SEL_STRIDE = 4;
   localparam int CTL_STRIDE = 4;
   localparam int CTL_END_BIT = 1;
   localparam int CTL_TS_BIT = 3;
   localparam logic [2:0] LAST_STEP = 3'h7;
   // status layout
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STEP_LSB = 4;

   typedef enum logic [1:0] {
      SSI_IDLE,
      SSI_SETUP,
      SSI_CONVERT
   } ssi_state_t;
endpackage

// ### rtl/ssi_seq_input_select.sv
// Function
// RULE1: step one samples the input named by bits 1:0, reset zero.
// RULE2: step two routes the input named by bits 5:4.
// RULE3: step three converts the input named by bits 9:8.
// RULE4: step four converts the input named by bits 13:12.
// RULE5: step five converts the input named by bits 17:16.
// RULE6: step six converts the input named by bits 21:20.
// RULE7: step seven converts the input named by bits 25:24.
// RULE8: step eight converts the input named by bits 29:28.
// RULE9: a selector value is the analog input pin number directly.
// RULE10: software ignores reserved pairs and writes them back unchanged.
// RULE11: steps after the first end flag are never converted.
// RULE12: a set temperature sensor bit reads the sensor, not the pin.
// RULE13: selector is presented before conversion, then advances each step; code loads the mux at the end of the conv_start cycle.
`timescale 1ns/1ns
module ssi_seq_input_select (
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer side
   input wire logic seq_start,
   input wire logic conv_done,
   output logic conv_start,
   output logic [1:0] analog_input_sel,
   output logic temp_sensor_select,
   output logic [2:0] active_step,
   output logic seq_busy,
   output logic seq_done
);
   logic [31:0] sequence0_input_select_r;
   logic [31:0] seq_ctrl_r;
   ssi_pkg::ssi_state_t state_r;
   logic [2:0] step_r;
   logic [1:0] cur_sel;
   logic cur_end;
   logic cur_ts;
   logic wr_en;
   logic rd_en;
   logic hit;

   // byte-lane merge of write data
   function automatic logic [31:0] strb_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      strb_merge = (new_v & m) | (old_v & ~m);
   endfunction

   // apb decode
   assign hit = (paddr == ssi_pkg::ADDR_INPUT_SEL) ||
                (paddr == ssi_pkg::ADDR_SEQ_CTRL) ||
                (paddr == ssi_pkg::ADDR_SEQ_STATUS);
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1; // zero wait states
   assign pslverr = psel && penable && !hit;

   // selector register; reserved pairs stay zero [RULE10]
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sequence0_input_select_r <= ssi_pkg::INPUT_SEL_RESET; // [RULE1]
      end else if (wr_en && paddr == ssi_pkg::ADDR_INPUT_SEL) begin
         sequence0_input_select_r <= strb_merge(sequence0_input_select_r,
            pwdata, pstrb) & ssi_pkg::INPUT_SEL_WMASK;
      end
   end

   // sequence control: end and sensor bits per step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seq_ctrl_r <= ssi_pkg::SEQ_CTRL_RESET;
      end else if (wr_en && paddr == ssi_pkg::ADDR_SEQ_CTRL) begin
         seq_ctrl_r <= strb_merge(seq_ctrl_r, pwdata, pstrb);
      end
   end

   // read data registered in the setup phase, held for the access phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ssi_pkg::ADDR_INPUT_SEL: prdata <= sequence0_input_select_r;
            ssi_pkg::ADDR_SEQ_CTRL: prdata <= seq_ctrl_r;
            ssi_pkg::ADDR_SEQ_STATUS: begin
               prdata <= 32'h0000_0000;
               prdata[ssi_pkg::STAT_BUSY_BIT] <= seq_busy;
               prdata[ssi_pkg::STAT_STEP_LSB +: 3] <= step_r;
            end
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // field selection for the current step [RULE1] [RULE2] [RULE3]
   // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
   ssi_field_pick u_pick (
      .sel_word(sequence0_input_select_r),
      .ctl_word(seq_ctrl_r),
      .step(step_r),
      .sel(cur_sel),
      .end_flag(cur_end),
      .ts_flag(cur_ts)
   );

   // step sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ssi_pkg::SSI_IDLE;
         step_r <= 3'h0;
         seq_done <= 1'b0;
      end else begin
         seq_done <= 1'b0;
         unique case (state_r)
            ssi_pkg::SSI_IDLE: begin
               if (seq_start) begin
                  step_r <= 3'h0;
                  state_r <= ssi_pkg::SSI_SETUP;
               end
            end
            // mux is loaded at the end of this cycle, the cycle in which conv_start is high [RULE13]
            ssi_pkg::SSI_SETUP: state_r <= ssi_pkg::SSI_CONVERT;
            ssi_pkg::SSI_CONVERT: begin
               if (conv_done) begin
                  if (cur_end || step_r == ssi_pkg::LAST_STEP) begin
                     state_r <= ssi_pkg::SSI_IDLE; // [RULE11]
                     seq_done <= 1'b1;
                  end else begin
                     step_r <= step_r + 3'h1; // [RULE13]
                     state_r <= ssi_pkg::SSI_SETUP;
                  end
               end
            end
         endcase
      end
   end

   // mux drive: selector value is the pin number [RULE9]
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         analog_input_sel <= 2'h0;
         temp_sensor_select <= 1'b0;
         active_step <= 3'h0;
      end else if (state_r == ssi_pkg::SSI_SETUP) begin
         analog_input_sel <= cur_sel; // [RULE13]
         temp_sensor_select <= cur_ts; // [RULE12]
         active_step <= step_r;
      end
   end

   assign conv_start = (state_r == ssi_pkg::SSI_SETUP);
   assign seq_busy = (state_r != ssi_pkg::SSI_IDLE);
endmodule // ssi_seq_input_select

// ### testbench/ssi_conv_model.sv
`timescale 1ns/1ns
module ssi_conv_model (
   input wire logic clk,
   input wire logic conv_start,
   output logic conv_done
);
   int n;
   // finish each conversion after a random latency
   initial begin
      conv_done = 1'h0;
      forever begin
         // look mid-cycle so the setup pulse is seen settled
         @(negedge clk);
         if (conv_start === 1'h1) begin
            n = $urandom_range(5, 1);
            repeat (n) @(posedge clk);
            conv_done <= 1'h1;
            @(posedge clk);
            conv_done <= 1'h0;
         end
      end
   end
endmodule // ssi_conv_model

// ### testbench/ssi_props.sv
`timescale 1ns/1ns
module ssi_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic seq_start,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [1:0] analog_input_sel,
   input wire logic temp_sensor_select,
   input wire logic [2:0] active_step,
   input wire logic seq_busy,
   input wire logic seq_done
);
   logic [31:0] sel_r;
   logic [31:0] ctl_r;
   logic wr;
   logic last;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // shadow copies of the selector and control words
   assign wr = psel && penable && pwrite;
   assign last = ctl_r[{active_step, 2'h1}] || active_step == 3'h7;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_r <= 32'h0;
         ctl_r <= 32'h0;
      end else if (wr && paddr == ssi_pkg::ADDR_INPUT_SEL) begin
         sel_r <= pwdata & 32'h3333_3333;
      end else if (wr && paddr == ssi_pkg::ADDR_SEQ_CTRL) begin
         ctl_r <= pwdata;
      end
   end
   a_sel_route: assert property (conv_start |=>
      analog_input_sel == sel_r[{active_step, 2'h0} +: 2]) else $error("sel");
   a_ts_route: assert property (conv_start |=>
      temp_sensor_select == ctl_r[{active_step, 2'h3}]) else $error("ts");
   a_sel_hold: assert property (!conv_start |=>
      $stable(analog_input_sel)) else $error("hold");
   a_step_next: assert property (conv_done && seq_busy && !last |=>
      conv_start ##1 active_step == $past(active_step, 2) + 3'h1)
      else $error("step");
   a_end_stop: assert property (conv_done && seq_busy && last |=>
      !conv_start ##[0:1] seq_done) else $error("end");
   a_seq_go: assert property (seq_start && !seq_busy |=>
      conv_start && seq_busy) else $error("go");
   a_start_once: assert property (conv_start |=> !conv_start)
      else $error("pulse");
   a_bad_addr: assert property (psel && penable && paddr == 12'h050 |->
      pslverr) else $error("slverr");
endmodule // ssi_props

// ### testbench/ssi_seq_input_select_tb_top.sv
`timescale 1ns/1ns
module ssi_seq_input_select_tb_top;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic seq_start = 0, conv_done, conv_start, pready, pslverr, seq_busy;
   logic seq_done, temp_sensor_select, e;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q, w, c;
   logic [3:0] pstrb = 4'hf;
   logic [1:0] analog_input_sel;
   logic [2:0] active_step;
   int num_errors = 0, cmp_count = 0, n;
   always #5 clk = ~clk;
   ssi_seq_input_select i_dut (.*);
   ssi_conv_model i_model (.clk(clk), .conv_start(conv_start),
      .conv_done(conv_done));
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   // one apb transfer, read data left in q
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int t;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      t = 0;
      do @(posedge clk); while (pready !== 1'h1 && t++ < 20);
      if (pready !== 1'h1) num_errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic int nsteps(logic [31:0] cw);
      for (int i = 0; i < 8; i++)
         if (cw[4*i+1]) return i + 1;
      return 8;
   endfunction
   task automatic wrap_up;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // random sequences, first one full length with all selectors at 3
   initial begin
      void'($urandom(32'haac76274));
      repeat (12) @(posedge clk);
      resetn <= 1'h1;
      apb(1'h0, ssi_pkg::ADDR_INPUT_SEL, 32'h0);
      chk("rst", 32'h0, q);
      chk("slverr_ok", 32'h0, e);
      apb(1'h0, 12'h050, 32'h0);
      chk("slverr_bad", 32'h1, e);
      for (int i = 0; i < 16; i++) begin
         w = i ? $urandom : 32'hffff_ffff;
         c = i ? $urandom & $urandom : 32'h0;
         apb(1'h1, ssi_pkg::ADDR_INPUT_SEL, w);
         apb(1'h1, ssi_pkg::ADDR_SEQ_CTRL, c);
         apb(1'h0, ssi_pkg::ADDR_INPUT_SEL, 32'h0);
         chk("rd", w & 32'h3333_3333, q);
         seq_start <= 1'h1;
         @(posedge clk);
         seq_start <= 1'h0;
         n = 0;
         repeat (99) begin
            @(negedge clk);
            if (conv_start === 1'h1 && n < 8) begin
               @(negedge clk);
               chk("sel", w[4*n+:2], analog_input_sel);
               chk("ts", c[4*n+3], temp_sensor_select);
               n++;
            end
         end
         chk("steps", nsteps(c), n);
      end
      wrap_up;
   end
   // watchdog
   initial begin
      #200000;
      num_errors++;
      wrap_up;
   end
endmodule // ssi_seq_input_select_tb_top
bind ssi_seq_input_select ssi_props i_props (.*);
